// file: core/lsf_pkg.sv
// Shared types and constants for the load/store formatter and address generator.
// Assumes one core clock domain; all request fields come from same-clock logic.
package lsf_pkg;

	// ----------------------------------------
	// Widths and constants
	// ----------------------------------------
	localparam int WORD_W = 32;
	localparam int WORDS = 4;
	localparam int LINE_W = WORD_W * WORDS;
	localparam int OFS_W = 12;
	localparam int IDX_W = 5;
	localparam int BYTE_MSB = 7;
	localparam int HALF_MSB = 15;
	localparam logic [31:0] IP_BIAS = 32'h0000_0008;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [127:0] LINE_RST = 128'h0;
	localparam logic [31:0] BIT_ONE = 32'h0000_0001;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {
		SZ_BYTE, SZ_HALF, SZ_WORD, SZ_LONG, SZ_TRIPLE, SZ_QUAD
	} lsf_size_e;

	typedef enum logic [3:0] {
		AM_ABS_OFS, AM_ABS_DISP, AM_RI, AM_RI_OFS, AM_RI_DISP,
		AM_RI_IDX, AM_RI_IDX_DISP, AM_IDX_DISP, AM_IP_DISP
	} lsf_mode_e;

	typedef enum logic [2:0] {SC_X1, SC_X2, SC_X4, SC_X8, SC_X16} lsf_scale_e;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic store;
		logic signd;
		lsf_size_e size;
		lsf_mode_e mode;
		lsf_scale_e scale;
		logic [OFS_W-1:0] offset;
		logic [31:0] disp;
		logic [31:0] abase;
		logic [31:0] index;
		logic [31:0] ip;
		logic [127:0] wdata;
	} lsf_req_s;

	typedef struct packed {
		logic valid;
		logic signd;
		lsf_size_e size;
		logic [127:0] rdata;
	} lsf_ret_s;

	typedef struct packed {
		logic [IDX_W-1:0] bit_num;
		logic [IDX_W-1:0] fld_len;
		logic [IDX_W-1:0] fld_low;
	} lsf_bitop_s;

	// ----------------------------------------
	// Size helpers
	// ----------------------------------------
	function automatic logic [2:0] words_of(input lsf_size_e sz);
		case (sz)
			SZ_LONG: words_of = 3'h2;
			SZ_TRIPLE: words_of = 3'h3;
			SZ_QUAD: words_of = 3'h4;
			default: words_of = 3'h1;
		endcase
	endfunction

	function automatic logic [3:0] align_mask(input lsf_size_e sz);
		case (sz)
			SZ_BYTE: align_mask = 4'h0;
			SZ_HALF: align_mask = 4'h1;
			SZ_WORD: align_mask = 4'h3;
			SZ_LONG: align_mask = 4'h7;
			default: align_mask = 4'hf;
		endcase
	endfunction

endpackage

// file: core/lsf_agu.sv
// Effective address generator, purely combinational.
// Assumes the caller registers the result and the mode enum is decoded upstream.
module lsf_agu (
	// Request
	input wire lsf_pkg::lsf_req_s req,
	// Result
	output logic [31:0] addr,
	output logic misaligned
);

	// ----------------------------------------
	// Term selection
	// ----------------------------------------
	wire use_base = req.mode inside {lsf_pkg::AM_RI, lsf_pkg::AM_RI_OFS, lsf_pkg::AM_RI_DISP,
		lsf_pkg::AM_RI_IDX, lsf_pkg::AM_RI_IDX_DISP};
	wire use_idx = req.mode inside {lsf_pkg::AM_RI_IDX, lsf_pkg::AM_RI_IDX_DISP,
		lsf_pkg::AM_IDX_DISP};
	wire use_ofs = req.mode inside {lsf_pkg::AM_ABS_OFS, lsf_pkg::AM_RI_OFS};
	wire use_disp = req.mode inside {lsf_pkg::AM_ABS_DISP, lsf_pkg::AM_RI_DISP,
		lsf_pkg::AM_RI_IDX_DISP, lsf_pkg::AM_IDX_DISP, lsf_pkg::AM_IP_DISP};
	wire is_ip = (req.mode == lsf_pkg::AM_IP_DISP);

	// Undefined scale codes fall back to x1 rather than producing a wild shift
	wire [2:0] shamt = (req.scale <= lsf_pkg::SC_X16) ? req.scale : 3'h0; // RULE_15

	wire [31:0] base_t = use_base ? req.abase : (is_ip ? req.ip : lsf_pkg::WORD_RST); // RULE_14
	wire [31:0] idx_t = use_idx ? (req.index << shamt) : lsf_pkg::WORD_RST; // RULE_15
	wire [31:0] ofs_t = use_ofs ? {20'h0, req.offset} // RULE_12
		: (use_disp ? req.disp : lsf_pkg::WORD_RST); // RULE_13
	wire [31:0] bias_t = is_ip ? lsf_pkg::IP_BIAS : lsf_pkg::WORD_RST; // RULE_17

	// ----------------------------------------
	// Sum
	// ----------------------------------------
	// Short-format modes carry the zero-extended small offset, extended ones the full disp
	// RULE_18
	// Nine modes all reduce to one four-term byte address
	// RULE_11
	// RULE_16
	// Carry out of bit 31 is dropped; address wrap is not an error
	assign addr = base_t + idx_t + ofs_t + bias_t; // RULE_19
	assign misaligned = |(addr[3:0] & lsf_pkg::align_mask(req.size)); // RULE_10

endmodule

// file: core/lsf_top.sv
// Load/store data formatter, bit and field mask builder and address stage.
// Assumes all inputs come from core-clock logic, so no synchronisers are used.
// One pipeline stage: each result appears one enabled edge after its request.

// Notes on behaviour
// RULE_01 - Signed narrow loads sign-extend to 32 bits
// RULE_02 - Signed narrow stores truncate, flag overflow
// RULE_03 - Word transfers pass unchanged
// RULE_04 - Unsigned narrow loads zero-extend
// RULE_05 - Unsigned narrow stores truncate, never overflow
// RULE_06 - Bit 0 is LSB, 31 MSB
// RULE_07 - Field length and low bit, one register
// RULE_08 - Multi-word transfers copy words untouched
// RULE_09 - Source keeps multi-word register operands aligned
// RULE_10 - Unaligned address: fault or auto-complete option
// RULE_11 - Nine modes give one byte address
// RULE_12 - Absolute offset is unsigned 0..4095
// RULE_13 - Absolute displacement is signed 32-bit
// RULE_14 - Register base is full 32 bits
// RULE_15 - Index scaled by 1,2,4,8,16
// RULE_16 - Indexed sums with and without base
// RULE_17 - IP relative adds displacement plus 8
// RULE_18 - Short offset versus extended displacement forms
// RULE_19 - Address sum wraps modulo 2^32
module lsf_top (
	// Clock, reset, enable
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic CE,
	// Access request from decoder and register file
	input wire lsf_pkg::lsf_req_s ACC_REQ,
	// Options from the core's control state
	input wire logic UNALIGN_FAULT_EN,
	input wire logic ARITH_OVF_MASK,
	// Load return from memory
	input wire lsf_pkg::lsf_ret_s LOAD_RET,
	// Bit and field operand selects
	input wire lsf_pkg::lsf_bitop_s BIT_OP,
	// Memory access
	output logic ACC_VALID,
	output logic ACC_STORE,
	output lsf_pkg::lsf_size_e ACC_SIZE,
	output logic [31:0] ACC_ADDR,
	output logic [127:0] ACC_WDATA,
	output logic ACC_UNALIGNED,
	// Faults and flags
	output logic ALIGN_FAULT,
	output logic ARITH_OVF_SET,
	output logic OVF_FAULT,
	// Load to register file
	output logic LOAD_VALID,
	output logic [127:0] LOAD_REG_DATA,
	// Bit and field masks
	output logic [31:0] BIT_MASK,
	output logic [31:0] FIELD_MASK
);

	// ----------------------------------------
	// Address generation
	// ----------------------------------------
	logic [31:0] agu_addr;
	logic agu_mis;

	lsf_agu u_agu (
		.req(ACC_REQ),
		.addr(agu_addr),
		.misaligned(agu_mis)
	);

	// ----------------------------------------
	// Alignment handling
	// ----------------------------------------
	wire req_v = ACC_REQ.valid;
	wire align_flt_nxt = req_v & agu_mis & UNALIGN_FAULT_EN; // RULE_10
	wire unaligned_nxt = req_v & agu_mis & ~UNALIGN_FAULT_EN; // RULE_10
	// An alignment-faulted access never reaches memory
	wire acc_valid_nxt = req_v & ~align_flt_nxt;

	// ----------------------------------------
	// Store formatting and overflow
	// ----------------------------------------
	wire [31:0] st_w0 = ACC_REQ.wdata[31:0];
	// Value fits a byte when bits 31..7 are all copies of the sign
	wire fit_b = (&st_w0[31:lsf_pkg::BYTE_MSB]) | ~(|st_w0[31:lsf_pkg::BYTE_MSB]);
	wire fit_h = (&st_w0[31:lsf_pkg::HALF_MSB]) | ~(|st_w0[31:lsf_pkg::HALF_MSB]);
	wire is_b_st = ACC_REQ.size == lsf_pkg::SZ_BYTE;
	wire is_h_st = ACC_REQ.size == lsf_pkg::SZ_HALF;
	// Unsigned stores never reach this term
	wire ovf = acc_valid_nxt & ACC_REQ.store & ACC_REQ.signd // RULE_05
		& ((is_b_st & ~fit_b) | (is_h_st & ~fit_h)); // RULE_02
	wire ovf_set_nxt = ovf & ARITH_OVF_MASK; // RULE_02
	wire ovf_flt_nxt = ovf & ~ARITH_OVF_MASK; // RULE_02

	// Truncated narrow store still writes its low bits
	wire [31:0] st_f0 = is_b_st ? {24'h0, st_w0[7:0]} // RULE_02
		: (is_h_st ? {16'h0, st_w0[15:0]} : st_w0); // RULE_03

	// ----------------------------------------
	// Load formatting
	// ----------------------------------------
	wire [31:0] ld_w0 = LOAD_RET.rdata[31:0];
	wire ext_b = LOAD_RET.signd & ld_w0[lsf_pkg::BYTE_MSB]; // RULE_01
	wire ext_h = LOAD_RET.signd & ld_w0[lsf_pkg::HALF_MSB]; // RULE_01
	wire [31:0] ld_f0 = (LOAD_RET.size == lsf_pkg::SZ_BYTE) ? {{24{ext_b}}, ld_w0[7:0]} // RULE_04
		: (LOAD_RET.size == lsf_pkg::SZ_HALF) ? {{16{ext_h}}, ld_w0[15:0]} // RULE_04
		: ld_w0; // RULE_03

	// ----------------------------------------
	// Multi-word lanes
	// ----------------------------------------
	wire [2:0] st_cnt = lsf_pkg::words_of(ACC_REQ.size);
	wire [2:0] ld_cnt = lsf_pkg::words_of(LOAD_RET.size);
	logic [127:0] st_line;
	logic [127:0] ld_line;

	assign st_line[31:0] = st_f0;
	assign ld_line[31:0] = ld_f0;

	// Upper words are copied verbatim; lanes past the size read as zero
	for (genvar w = 1; w < lsf_pkg::WORDS; w++) begin : g_lane
		assign st_line[w*32 +: 32] = (3'(w) < st_cnt) // RULE_08
			? ACC_REQ.wdata[w*32 +: 32] : lsf_pkg::WORD_RST;
		assign ld_line[w*32 +: 32] = (3'(w) < ld_cnt) // RULE_08
			? LOAD_RET.rdata[w*32 +: 32] : lsf_pkg::WORD_RST;
	end

	// ----------------------------------------
	// Bit and field masks
	// ----------------------------------------
	wire [31:0] bit_nxt = lsf_pkg::BIT_ONE << BIT_OP.bit_num; // RULE_06
	wire [5:0] fld_top = {1'b0, BIT_OP.fld_low} + {1'b0, BIT_OP.fld_len};
	logic [31:0] fld_nxt;

	// Bits at or above 32 simply do not exist, so a field is cut at bit 31
	for (genvar b = 0; b < lsf_pkg::WORD_W; b++) begin : g_fld
		assign fld_nxt[b] = (5'(b) >= BIT_OP.fld_low) && (6'(b) < fld_top); // RULE_07
	end

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	// CE low freezes everything, so one-cycle pulses stretch while it stays low
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ACC_VALID <= 1'b0;
			ACC_STORE <= 1'b0;
			ACC_SIZE <= lsf_pkg::SZ_BYTE;
			ACC_ADDR <= lsf_pkg::WORD_RST;
			ACC_WDATA <= lsf_pkg::LINE_RST;
			ACC_UNALIGNED <= 1'b0;
			ALIGN_FAULT <= 1'b0;
			ARITH_OVF_SET <= 1'b0;
			OVF_FAULT <= 1'b0;
		end else if (CE) begin
			ACC_VALID <= acc_valid_nxt;
			ACC_STORE <= ACC_REQ.store;
			ACC_SIZE <= ACC_REQ.size;
			ACC_ADDR <= agu_addr; // RULE_11
			ACC_WDATA <= st_line;
			ACC_UNALIGNED <= unaligned_nxt;
			ALIGN_FAULT <= align_flt_nxt;
			ARITH_OVF_SET <= ovf_set_nxt;
			OVF_FAULT <= ovf_flt_nxt;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			LOAD_VALID <= 1'b0;
			LOAD_REG_DATA <= lsf_pkg::LINE_RST;
			BIT_MASK <= lsf_pkg::BIT_ONE;
			FIELD_MASK <= lsf_pkg::WORD_RST;
		end else if (CE) begin
			LOAD_VALID <= LOAD_RET.valid;
			LOAD_REG_DATA <= ld_line;
			BIT_MASK <= bit_nxt;
			FIELD_MASK <= fld_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);

	wire chk_sb = LOAD_RET.valid & LOAD_RET.signd & (LOAD_RET.size == lsf_pkg::SZ_BYTE);
	wire chk_uh = LOAD_RET.valid & ~LOAD_RET.signd & (LOAD_RET.size == lsf_pkg::SZ_HALF);
	wire chk_w = LOAD_RET.valid & (LOAD_RET.size == lsf_pkg::SZ_WORD);
	wire chk_ovf = acc_valid_nxt & ACC_REQ.store & ACC_REQ.signd & is_b_st & ~fit_b;
	wire chk_ust = req_v & ACC_REQ.store & ~ACC_REQ.signd;
	wire chk_q = acc_valid_nxt & ACC_REQ.store & (ACC_REQ.size == lsf_pkg::SZ_QUAD);
	wire chk_ip = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_IP_DISP);
	wire chk_ao = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_ABS_OFS);
	wire chk_id = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_IDX_DISP)
		& (ACC_REQ.scale == lsf_pkg::SC_X4);
	wire chk_af = req_v & agu_mis & UNALIGN_FAULT_EN;
	wire chk_ad = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_ABS_DISP);
	wire chk_rb = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_RI);
	wire chk_rx = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_RI_IDX)
		& (ACC_REQ.scale == lsf_pkg::SC_X16);
	wire chk_ro = acc_valid_nxt & (ACC_REQ.mode == lsf_pkg::AM_RI_OFS);
	// Reset is read as sampled, so the release edge, whose results are still reset values,
	// starts no check even with CE already high
	wire chk_on = CE & RESET_N;

	property p_sext_byte;
		chk_on && chk_sb |=> LOAD_REG_DATA[31:0] == {{24{$past(ld_w0[7])}}, $past(ld_w0[7:0])};
	endproperty
	a_sext_byte: assert property (p_sext_byte) else $error("signed byte load not extended"); // RULE_01

	property p_ovf_flag;
		chk_on && chk_ovf |=> (ARITH_OVF_SET ^ OVF_FAULT) && ARITH_OVF_SET == $past(ARITH_OVF_MASK)
			&& ACC_WDATA[31:8] == 24'h0;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("byte overflow not signalled"); // RULE_02

	property p_word_pass;
		chk_on && chk_w |=> LOAD_REG_DATA[31:0] == $past(ld_w0);
	endproperty
	a_word_pass: assert property (p_word_pass) else $error("word load altered"); // RULE_03

	property p_zext_half;
		chk_on && chk_uh |=> LOAD_REG_DATA[31:16] == 16'h0
			&& LOAD_REG_DATA[15:0] == $past(ld_w0[15:0]);
	endproperty
	a_zext_half: assert property (p_zext_half) else $error("unsigned half not zero-extended"); // RULE_04

	property p_no_ovf_uns;
		chk_on && chk_ust |=> !ARITH_OVF_SET && !OVF_FAULT;
	endproperty
	a_no_ovf_uns: assert property (p_no_ovf_uns) else $error("unsigned store flagged overflow"); // RULE_05

	property p_bit_sel;
		chk_on |=> $onehot(BIT_MASK) && BIT_MASK[$past(BIT_OP.bit_num)];
	endproperty
	a_bit_sel: assert property (p_bit_sel) else $error("bit mask wrong"); // RULE_06

	property p_field;
		chk_on |=> $countones(FIELD_MASK) <= $past(BIT_OP.fld_len)
			&& (FIELD_MASK & ~(32'hffff_ffff << $past(BIT_OP.fld_low))) == 32'h0;
	endproperty
	a_field: assert property (p_field) else $error("field mask out of bounds"); // RULE_07

	property p_quad_copy;
		chk_on && chk_q |=> ACC_WDATA == $past(ACC_REQ.wdata);
	endproperty
	a_quad_copy: assert property (p_quad_copy) else $error("quad store altered"); // RULE_08

	property p_align;
		chk_on && chk_af |=> ALIGN_FAULT && !ACC_VALID && !ACC_UNALIGNED;
	endproperty
	a_align: assert property (p_align) else $error("unaligned fault not raised"); // RULE_10

	property p_ip_addr;
		chk_on && chk_ip |=> ACC_VALID
			&& ACC_ADDR == $past(ACC_REQ.ip) + $past(ACC_REQ.disp) + lsf_pkg::IP_BIAS;
	endproperty
	a_ip_addr: assert property (p_ip_addr) else $error("IP relative address wrong"); // RULE_17

	property p_abs_ofs;
		chk_on && chk_ao |=> ACC_ADDR == {20'h0, $past(ACC_REQ.offset)};
	endproperty
	a_abs_ofs: assert property (p_abs_ofs) else $error("absolute offset address wrong"); // RULE_12

	property p_idx_disp;
		chk_on && chk_id |=> ACC_ADDR == ($past(ACC_REQ.index) << 2) + $past(ACC_REQ.disp);
	endproperty
	a_idx_disp: assert property (p_idx_disp) else $error("index plus disp address wrong"); // RULE_16

	property p_abs_disp;
		chk_on && chk_ad |=> ACC_ADDR == $past(ACC_REQ.disp);
	endproperty
	a_abs_disp: assert property (p_abs_disp) else $error("abs disp address wrong"); // RULE_13

	property p_ri_base;
		chk_on && chk_rb |=> ACC_ADDR == $past(ACC_REQ.abase);
	endproperty
	a_ri_base: assert property (p_ri_base) else $error("register base address wrong"); // RULE_14

	property p_ri_idx;
		chk_on && chk_rx |=> ACC_ADDR == $past(ACC_REQ.abase) + ($past(ACC_REQ.index) << 4);
	endproperty
	a_ri_idx: assert property (p_ri_idx) else $error("scaled index address wrong"); // RULE_15

	property p_ri_ofs;
		chk_on && chk_ro |=> ACC_ADDR == $past(ACC_REQ.abase) + {20'h0, $past(ACC_REQ.offset)};
	endproperty
	a_ri_ofs: assert property (p_ri_ofs) else $error("short offset address wrong"); // RULE_18

	property p_cov_ovf;
		chk_on && chk_ovf;
	endproperty
	c_cov_ovf: cover property (p_cov_ovf);

	property p_cov_ip;
		chk_on && chk_ip;
	endproperty
	c_cov_ip: cover property (p_cov_ip);

	property p_cov_quad;
		chk_on && chk_q;
	endproperty
	c_cov_quad: cover property (p_cov_quad);

	property p_cov_af;
		chk_on && chk_af;
	endproperty
	c_cov_af: cover property (p_cov_af);

endmodule

// file: verification/lsf_mem_model.sv
// Memory-side model: answers each issued load with data, promptly or slowly.
// Assumes the block's core clock and clock enable; stores are only absorbed.
module lsf_mem_model (
	// Clock, reset, pacing
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic slow,
	// Access from the block
	input wire logic acc_valid,
	input wire logic acc_store,
	input wire lsf_pkg::lsf_size_e acc_size,
	input wire logic [31:0] acc_addr,
	// Load return
	output lsf_pkg::lsf_ret_s ret
);
	timeunit 1ns;
	timeprecision 1ps;
	lsf_pkg::lsf_ret_s pipe_r [4];
	logic [127:0] idle_r;
	// ----------------------------------------
	// Read pipeline
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) pipe_r[i] <= '0;
			idle_r <= 128'h5a5a_c3c3_0ff0_a5a5_9669_3cc3_f00f_6996;
		end else if (ce) begin
			pipe_r[0].valid <= acc_valid && !acc_store;
			pipe_r[0].signd <= acc_addr[4];
			pipe_r[0].size <= acc_size;
			// Words ascend into an aligned register group; junk above narrow data
			pipe_r[0].rdata <= {~acc_addr, acc_addr ^ 32'h3c96_a5f1,
				acc_addr + 32'h1357_9bdf, {4{acc_addr[7:0]}} ^ 32'h0f0f_8080};
			for (int i = 1; i < 4; i++) pipe_r[i] <= pipe_r[i-1];
			idle_r <= ~idle_r;
		end
	end
	// Released bus toggles so a stale word can never pass for fresh data
	always_comb begin
		ret = slow ? pipe_r[3] : pipe_r[0];
		if (!ret.valid) ret.rdata = idle_r;
	end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the load/store formatter and address stage.
// Assumes one core clock; a reference model predicts every output per enabled edge.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset_n, ce, ufe, omask, slow;
	logic armed = 1'b0;
	lsf_pkg::lsf_req_s req;
	lsf_pkg::lsf_ret_s lret;
	lsf_pkg::lsf_bitop_s bop;
	logic acc_valid, acc_store, acc_unal, al_flt, ovf_set, ovf_flt, ld_valid;
	lsf_pkg::lsf_size_e acc_size;
	logic [31:0] acc_addr, bit_mask, fld_mask, e_addr, e_bm, e_fm, seed;
	logic [127:0] acc_wd, ld_data, e_wd, e_ld;
	logic [2:0] e_fl, e_sz;
	logic [1:0] e_ov;
	logic e_st, e_lv, mis, fx, ov;
	int n_errors, check_count;
	lsf_top uut (.REF_CLK(ref_clk), .RESET_N(reset_n), .CE(ce), .ACC_REQ(req),
		.UNALIGN_FAULT_EN(ufe), .ARITH_OVF_MASK(omask), .LOAD_RET(lret), .BIT_OP(bop),
		.ACC_VALID(acc_valid), .ACC_STORE(acc_store), .ACC_SIZE(acc_size),
		.ACC_ADDR(acc_addr), .ACC_WDATA(acc_wd), .ACC_UNALIGNED(acc_unal),
		.ALIGN_FAULT(al_flt), .ARITH_OVF_SET(ovf_set), .OVF_FAULT(ovf_flt),
		.LOAD_VALID(ld_valid), .LOAD_REG_DATA(ld_data), .BIT_MASK(bit_mask),
		.FIELD_MASK(fld_mask));
	lsf_mem_model mem (.clk(ref_clk), .rst_n(reset_n), .ce(ce), .slow(slow),
		.acc_valid(acc_valid), .acc_store(acc_store), .acc_size(acc_size),
		.acc_addr(acc_addr), .ret(lret));
	// ----------------------------------------
	// Reference functions
	// ----------------------------------------
	function automatic logic [31:0] f_addr(lsf_pkg::lsf_req_s r);
		logic [31:0] sx;
		sx = r.index << r.scale;
		case (r.mode)
			lsf_pkg::AM_ABS_OFS: return {20'h0, r.offset};
			lsf_pkg::AM_ABS_DISP: return r.disp;
			lsf_pkg::AM_RI: return r.abase;
			lsf_pkg::AM_RI_OFS: return r.abase + {20'h0, r.offset};
			lsf_pkg::AM_RI_DISP: return r.abase + r.disp;
			lsf_pkg::AM_RI_IDX: return r.abase + sx;
			lsf_pkg::AM_RI_IDX_DISP: return r.abase + sx + r.disp;
			lsf_pkg::AM_IDX_DISP: return sx + r.disp;
			default: return r.ip + r.disp + 32'h0000_0008;
		endcase
	endfunction
	function automatic logic [127:0] f_fmt(logic [127:0] d, lsf_pkg::lsf_size_e sz, logic sg);
		case (sz)
			lsf_pkg::SZ_BYTE: return {96'h0, {24{sg & d[7]}}, d[7:0]};
			lsf_pkg::SZ_HALF: return {96'h0, {16{sg & d[15]}}, d[15:0]};
			lsf_pkg::SZ_WORD: return {96'h0, d[31:0]};
			lsf_pkg::SZ_LONG: return {64'h0, d[63:0]};
			lsf_pkg::SZ_TRIPLE: return {32'h0, d[95:0]};
			default: return d;
		endcase
	endfunction
	function automatic logic [3:0] f_mask(lsf_pkg::lsf_size_e sz);
		return sz == lsf_pkg::SZ_BYTE ? 4'h0 : sz == lsf_pkg::SZ_HALF ? 4'h1 :
			sz == lsf_pkg::SZ_WORD ? 4'h3 : sz == lsf_pkg::SZ_LONG ? 4'h7 : 4'hf;
	endfunction
	// ----------------------------------------
	// Prediction and comparison
	// ----------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		armed = 1'b1;
		if (!reset_n) begin
			{e_fl, e_ov, e_st, e_sz, e_addr, e_wd, e_lv, e_ld, e_fm} = '0;
			e_bm = 32'h0000_0001;
		end else if (ce) begin
			e_addr = f_addr(req);
			mis = |(e_addr[3:0] & f_mask(req.size));
			fx = req.valid && mis && ufe;
			e_fl = {req.valid && !fx, fx, req.valid && mis && !ufe};
			ov = req.valid && req.store && req.signd && !fx &&
				(req.size == lsf_pkg::SZ_BYTE ? req.wdata[31:7] != {25{req.wdata[7]}} :
				req.size == lsf_pkg::SZ_HALF && req.wdata[31:15] != {17{req.wdata[15]}});
			e_ov = {ov && omask, ov && !omask};
			e_st = req.store;
			e_sz = req.size;
			e_wd = f_fmt(req.wdata, req.size, 1'b0);
			e_lv = lret.valid;
			e_ld = f_fmt(lret.rdata, lret.size, lret.signd);
			e_bm = 32'h0000_0001 << bop.bit_num;
			e_fm = 32'(((64'h1 << bop.fld_len) - 64'h1) << bop.fld_low);
		end
	end
	task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	always @(negedge ref_clk) begin
		if (armed) begin
			check({acc_valid, al_flt, acc_unal}, e_fl, "issue flags");
			check({ovf_set, ovf_flt}, e_ov, "overflow");
			check({acc_store, acc_size}, {e_st, e_sz}, "kind");
			check(acc_addr, e_addr, "address");
			if (e_fl[2]) check(acc_wd, e_wd, "store data");
			check(ld_valid, e_lv, "load valid");
			if (e_lv) check(ld_data, e_ld, "load data");
			check(bit_mask, e_bm, "bit mask");
			check(fld_mask, e_fm, "field mask");
		end
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic put(lsf_pkg::lsf_req_s r, logic f, logic m);
		req <= r;
		ufe <= f;
		omask <= m;
		@(posedge ref_clk);
	endtask
	task automatic rnd();
		logic [287:0] b;
		lsf_pkg::lsf_req_s r;
		for (int i = 0; i < 9; i++) b[i*32+:32] = $random(seed);
		r = b[280:0];
		r.size = lsf_pkg::lsf_size_e'(3'({$random(seed)} % 6));
		r.mode = lsf_pkg::lsf_mode_e'(4'({$random(seed)} % 9));
		r.scale = lsf_pkg::lsf_scale_e'(3'({$random(seed)} % 5));
		// Small values keep some signed narrow stores in range
		if (b[287]) r.wdata[31:0] = {{24{b[286]}}, b[286:279]};
		bop <= 15'($random(seed));
		// Enable rides with the request so one edge never sees two writes to it
		ce <= b[282:281] != 2'b00;
		put(r, b[284], b[283]);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		n_errors++;
		$display("BAD %0t run did not finish", $time);
		end_sim();
	end
	initial begin
		lsf_pkg::lsf_req_s r;
		{reset_n, ce, ufe, omask, slow, n_errors, check_count} = '0;
		{req, bop} = '0;
		seed = 32'h150e;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		ce <= 1'b1;
		$display("test reset done");
		r = '0;
		r.valid = 1'b1;
		r.store = 1'b1;
		r.signd = 1'b1;
		r.mode = lsf_pkg::AM_IP_DISP;
		r.ip = 32'h0000_0064;
		r.disp = 32'h0000_0004;
		r.wdata = 128'h180;
		put(r, 1'b0, 1'b0);
		put(r, 1'b0, 1'b1);
		r.wdata = 128'hffff_ff80;
		put(r, 1'b0, 1'b0);
		r.size = lsf_pkg::SZ_WORD;
		put(r, 1'b1, 1'b0);
		put(r, 1'b0, 1'b0);
		$display("test store corners done");
		for (int m = 0; m < 9; m++) begin
			for (int s = 0; s < 5; s++) begin
				r = {1'b1, 1'(s), 4'h0, 4'(m), 3'(s), 12'hfff, 32'hffff_fff8, 32'hffff_fff0,
					32'h1000_0001, 32'hffff_fff4, 128'h0};
				put(r, 1'b0, 1'b0);
			end
		end
		$display("test address modes done");
		repeat (1500) rnd();
		slow <= 1'b1;
		repeat (1500) rnd();
		$display("test random done");
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (200) rnd();
		$display("test second reset done");
		end_sim();
	end
endmodule
